// ---- include/oss_map.vh ----
// oss_map.vh: source codes and timing constants for the output source selector
// assumes: included by core/oss_selector.v and by the checker and the bench
`ifndef OSS_MAP_VH
`define OSS_MAP_VH
`define OSS_SEL_W 7
`define OSS_SRC_GROSS_OVSPD 7'h2f
`define OSS_SRC_START_RELAY 7'h30
`define OSS_SRC_TEMP_OPEN 7'h31
`define OSS_SRC_UNDER_FREQ 7'h32
`define OSS_SRC_UNDER_SPEED 7'h33
`define OSS_SRC_MAINT_DUE 7'h34
`define OSS_SRC_STOP_MODE 7'h35
`define OSS_SRC_AUTO_MODE 7'h36
`define OSS_SRC_MANUAL_MODE 7'h37
`define OSS_SRC_PREHEAT 7'h38
`define OSS_SRC_FUEL_XFER 7'h39
`define OSS_SRC_VALVE_PULL 7'h3a
`define OSS_SRC_VALVE_HOLD 7'h3b
`define OSS_SRC_LOW_IDLE 7'h3c
`define OSS_SRC_COOLANT 7'h3d
`define OSS_SRC_KEYSWITCH 7'h3e
`define OSS_SRC_GEN_OPEN 7'h3f
`define OSS_SRC_GEN_CLOSE 7'h40
`define OSS_SRC_MAINS_OPEN 7'h41
`define OSS_SRC_MAINS_CLOSE 7'h42
`define OSS_SRC_IDLE_ON 7'h43
`define OSS_SRC_IDLE_OFF 7'h44
`define OSS_CLK_MHZ 125
`define OSS_PULSE_MS_DEF 1000
`define OSS_PULL_MS_DEF 2000
`define OSS_CYC_PER_MS (`OSS_CLK_MHZ * 1000)
`define OSS_PULSE_CYC_DEF (`OSS_PULSE_MS_DEF * `OSS_CYC_PER_MS)
`define OSS_PULL_CYC_DEF (`OSS_PULL_MS_DEF * `OSS_CYC_PER_MS)
`define OSS_CNT_W 32
`endif

// ---- core/oss_selector.v ----
// oss_selector.v: per-output source selector with pulse and latch generators
// assumes: condition flags come from logic on clk_in; durations in clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "oss_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - code 47 gross overspeed shutdown alarm
// - code 48 follows starter relay drive
// - code 49 temperature sensor open alarm
// - code 50 under-frequency shutdown alarm
// - code 51 under-speed shutdown alarm
// - code 52 maintenance due alarm
// - code 53 stop sequence initiated
// - code 54 automatic mode active
// - code 55 manual mode active
// - code 56 preheat from start until timer expiry
// - code 57 mirrors automatic fuel transfer drive
// - code 58 high for set time after start
// - code 59 start sets, stop plus stopped clears
// - code 60 low idle speed
// - code 61 coolant outside set-point band
// - code 62 on in start, off in stop
// - codes 63/64 gen breaker open/close pulse
// - codes 65/66 mains breaker open/close pulse
// - codes 67/68 idle mode on/off pulse
module oss_selector #(
  parameter N_OUT = 8,
  parameter [31:0] PULSE_CYC = `OSS_PULSE_CYC_DEF,
  parameter [31:0] PULL_CYC = `OSS_PULL_CYC_DEF
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire [N_OUT*`OSS_SEL_W-1:0] sel_flat_in,
  input wire gross_overspeed_in,
  input wire start_relay_in,
  input wire temp_open_in,
  input wire under_freq_in,
  input wire under_speed_in,
  input wire maint_due_in,
  input wire stop_seq_in,
  input wire auto_mode_in,
  input wire manual_mode_in,
  input wire preheat_start_in,
  input wire preheat_expired_in,
  input wire fuel_xfer_in,
  input wire start_cmd_in,
  input wire stop_cmd_in,
  input wire engine_stopped_in,
  input wire low_idle_in,
  input wire coolant_out_band_in,
  input wire start_seq_in,
  input wire gen_open_req_in,
  input wire gen_close_req_in,
  input wire mains_open_req_in,
  input wire mains_close_req_in,
  input wire idle_on_req_in,
  input wire idle_off_req_in,
  output wire injector_valve_pull_out,
  output wire injector_valve_hold_out,
  output reg [N_OUT-1:0] pins_out
);

////////////////////////////////////////////////////////////////////////////////
// preheat, valve pull and valve hold state

reg preheat_q;
reg hold_q;
reg stop_seen_q;
reg start_cmd_q;
reg pull_q;
reg [`OSS_CNT_W-1:0] pull_cnt_q;
wire start_rise = start_cmd_in & ~start_cmd_q;

assign injector_valve_pull_out = pull_q;
assign injector_valve_hold_out = hold_q;

always @(posedge clk_in or negedge arst_n_in) begin
  if (!arst_n_in) begin
    preheat_q <= 1'b0;
    hold_q <= 1'b0;
    stop_seen_q <= 1'b0;
    start_cmd_q <= 1'b0;
    pull_q <= 1'b0;
    pull_cnt_q <= {`OSS_CNT_W{1'b0}};
  end else begin
    start_cmd_q <= start_cmd_in;
    if (preheat_expired_in) begin
      preheat_q <= 1'b0;
    end else if (preheat_start_in) begin
      preheat_q <= 1'b1;
    end
    if (start_rise) begin
      pull_q <= 1'b1;
      pull_cnt_q <= PULL_CYC;
    end else if (pull_q) begin
      if (pull_cnt_q <= 32'h0000_0001) begin
        pull_q <= 1'b0;
        pull_cnt_q <= {`OSS_CNT_W{1'b0}};
      end else begin
        pull_cnt_q <= pull_cnt_q - 32'h0000_0001;
      end
    end
    if (start_cmd_in) begin
      hold_q <= 1'b1;
      stop_seen_q <= 1'b0;
    end else if (hold_q) begin
      if ((stop_seen_q | stop_cmd_in) & engine_stopped_in) begin
        hold_q <= 1'b0;
        stop_seen_q <= 1'b0;
      end else if (stop_cmd_in) begin
        stop_seen_q <= 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// breaker and idle pulse generators

localparam N_PLS = 6;
wire [N_PLS-1:0] req_w = {idle_off_req_in, idle_on_req_in, mains_close_req_in,
                          mains_open_req_in, gen_close_req_in, gen_open_req_in};
reg [N_PLS-1:0] req_q;
reg [N_PLS-1:0] pls_q;
reg [`OSS_CNT_W-1:0] pls_cnt_q [0:N_PLS-1];
integer p;

always @(posedge clk_in or negedge arst_n_in) begin
  if (!arst_n_in) begin
    req_q <= {N_PLS{1'b0}};
    pls_q <= {N_PLS{1'b0}};
    for (p = 0; p < N_PLS; p = p + 1) begin
      pls_cnt_q[p] <= {`OSS_CNT_W{1'b0}};
    end
  end else begin
    req_q <= req_w;
    for (p = 0; p < N_PLS; p = p + 1) begin
      if (req_w[p] & ~req_q[p] & ~pls_q[p]) begin
        pls_q[p] <= 1'b1;
        pls_cnt_q[p] <= PULSE_CYC;
      end else if (pls_q[p]) begin
        if (pls_cnt_q[p] <= 32'h0000_0001) begin
          pls_q[p] <= 1'b0;
          pls_cnt_q[p] <= {`OSS_CNT_W{1'b0}};
        end else begin
          pls_cnt_q[p] <= pls_cnt_q[p] - 32'h0000_0001;
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// condition vector bit positions

localparam C_GROSS = 0;
localparam C_START_RELAY = 1;
localparam C_TEMP_OPEN = 2;
localparam C_UNDER_FREQ = 3;
localparam C_UNDER_SPEED = 4;
localparam C_MAINT_DUE = 5;
localparam C_STOP_MODE = 6;
localparam C_AUTO_MODE = 7;
localparam C_MANUAL_MODE = 8;
localparam C_PREHEAT = 9;
localparam C_FUEL_XFER = 10;
localparam C_VALVE_PULL = 11;
localparam C_VALVE_HOLD = 12;
localparam C_LOW_IDLE = 13;
localparam C_COOLANT = 14;
localparam C_KEYSWITCH = 15;
localparam C_GEN_OPEN = 16;
localparam C_GEN_CLOSE = 17;
localparam C_MAINS_OPEN = 18;
localparam C_MAINS_CLOSE = 19;
localparam C_IDLE_ON = 20;
localparam C_IDLE_OFF = 21;

////////////////////////////////////////////////////////////////////////////////
// source decode

function src_pick;
  input [`OSS_SEL_W-1:0] code;
  input [27:0] c;
  begin
    case (code)
      `OSS_SRC_GROSS_OVSPD: src_pick = c[C_GROSS];
      `OSS_SRC_START_RELAY: src_pick = c[C_START_RELAY];
      `OSS_SRC_TEMP_OPEN: src_pick = c[C_TEMP_OPEN];
      `OSS_SRC_UNDER_FREQ: src_pick = c[C_UNDER_FREQ];
      `OSS_SRC_UNDER_SPEED: src_pick = c[C_UNDER_SPEED];
      `OSS_SRC_MAINT_DUE: src_pick = c[C_MAINT_DUE];
      `OSS_SRC_STOP_MODE: src_pick = c[C_STOP_MODE];
      `OSS_SRC_AUTO_MODE: src_pick = c[C_AUTO_MODE];
      `OSS_SRC_MANUAL_MODE: src_pick = c[C_MANUAL_MODE];
      `OSS_SRC_PREHEAT: src_pick = c[C_PREHEAT];
      `OSS_SRC_FUEL_XFER: src_pick = c[C_FUEL_XFER];
      `OSS_SRC_VALVE_PULL: src_pick = c[C_VALVE_PULL];
      `OSS_SRC_VALVE_HOLD: src_pick = c[C_VALVE_HOLD];
      `OSS_SRC_LOW_IDLE: src_pick = c[C_LOW_IDLE];
      `OSS_SRC_COOLANT: src_pick = c[C_COOLANT];
      `OSS_SRC_KEYSWITCH: src_pick = c[C_KEYSWITCH];
      `OSS_SRC_GEN_OPEN: src_pick = c[C_GEN_OPEN];
      `OSS_SRC_GEN_CLOSE: src_pick = c[C_GEN_CLOSE];
      `OSS_SRC_MAINS_OPEN: src_pick = c[C_MAINS_OPEN];
      `OSS_SRC_MAINS_CLOSE: src_pick = c[C_MAINS_CLOSE];
      `OSS_SRC_IDLE_ON: src_pick = c[C_IDLE_ON];
      `OSS_SRC_IDLE_OFF: src_pick = c[C_IDLE_OFF];
      default: src_pick = 1'b0;
    endcase
  end
endfunction

// keyswitch: on during start sequence, forced off during stop
wire key_w = start_seq_in & ~stop_seq_in;
wire [27:0] cond_w;
assign cond_w[C_GROSS] = gross_overspeed_in;
assign cond_w[C_START_RELAY] = start_relay_in;
assign cond_w[C_TEMP_OPEN] = temp_open_in;
assign cond_w[C_UNDER_FREQ] = under_freq_in;
assign cond_w[C_UNDER_SPEED] = under_speed_in;
assign cond_w[C_MAINT_DUE] = maint_due_in;
assign cond_w[C_STOP_MODE] = stop_seq_in;
assign cond_w[C_AUTO_MODE] = auto_mode_in;
assign cond_w[C_MANUAL_MODE] = manual_mode_in;
assign cond_w[C_PREHEAT] = preheat_q;
assign cond_w[C_FUEL_XFER] = fuel_xfer_in;
assign cond_w[C_VALVE_PULL] = pull_q;
assign cond_w[C_VALVE_HOLD] = hold_q;
assign cond_w[C_LOW_IDLE] = low_idle_in;
assign cond_w[C_COOLANT] = coolant_out_band_in;
assign cond_w[C_KEYSWITCH] = key_w;
assign cond_w[C_GEN_OPEN] = pls_q[0];
assign cond_w[C_GEN_CLOSE] = pls_q[1];
assign cond_w[C_MAINS_OPEN] = pls_q[2];
assign cond_w[C_MAINS_CLOSE] = pls_q[3];
assign cond_w[C_IDLE_ON] = pls_q[4];
assign cond_w[C_IDLE_OFF] = pls_q[5];
// spare positions, never selected
assign cond_w[27:22] = 6'h00;
integer i;

always @(posedge clk_in or negedge arst_n_in) begin
  if (!arst_n_in) begin
    pins_out <= {N_OUT{1'b0}};
  end else begin
    for (i = 0; i < N_OUT; i = i + 1) begin
      pins_out[i] <= src_pick(sel_flat_in[i*`OSS_SEL_W +: `OSS_SEL_W], cond_w);
    end
  end
end

endmodule
`default_nettype wire

// ---- verification/oss_relay_model.sv ----
// oss_relay_model.sv: relay coil on output 0, counts pick-ups
// assumes: coil sampled on clk_in
`timescale 1ns/1ps
`default_nettype none
module oss_relay_model (
  input wire logic clk_in,
  input wire logic coil_in,
  output var logic [7:0] pick_count_out
);
  logic coil_q = 1'b0;
  initial pick_count_out = 8'h00;
  always @(posedge clk_in) begin
    if (coil_in && !coil_q) pick_count_out <= pick_count_out + 8'h01;
    coil_q <= coil_in;
  end
endmodule
`default_nettype wire

// ---- verification/oss_selector_checker.sv ----
// oss_selector_checker.sv: port assertions for the source selector
// assumes: pull count 6, pulse count 4
`timescale 1ns/1ps
`default_nettype none
`include "oss_map.vh"
module oss_selector_checker #(
  parameter N_OUT = 8
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire [N_OUT*`OSS_SEL_W-1:0] sel_flat_in,
  input wire gross_overspeed_in,
  input wire auto_mode_in,
  input wire start_seq_in,
  input wire stop_seq_in,
  input wire start_cmd_in,
  input wire engine_stopped_in,
  input wire gen_open_req_in,
  input wire injector_valve_pull_out,
  input wire injector_valve_hold_out,
  input wire [N_OUT-1:0] pins_out
);
  wire [6:0] s0 = sel_flat_in[6:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  a_gross_ovspd: assert property (s0 == `OSS_SRC_GROSS_OVSPD |=> pins_out[0] == $past(gross_overspeed_in))
    else $error("gross overspeed pin wrong");
  a_auto_mode: assert property (s0 == `OSS_SRC_AUTO_MODE |=> pins_out[0] == $past(auto_mode_in))
    else $error("auto mode pin wrong");
  a_key_switch: assert property (s0 == `OSS_SRC_KEYSWITCH |=> pins_out[0] == $past(start_seq_in && !stop_seq_in))
    else $error("keyswitch pin wrong");
  a_unknown_zero: assert property (s0 < `OSS_SRC_GROSS_OVSPD |=> !pins_out[0])
    else $error("unmapped code drives pin");
  a_pull_width: assert property ($rose(start_cmd_in) |=> injector_valve_pull_out [*6] ##1 !injector_valve_pull_out)
    else $error("pull width wrong");
  a_hold_set: assert property (start_cmd_in |=> injector_valve_hold_out)
    else $error("hold not set");
  a_hold_keep: assert property (injector_valve_hold_out && !engine_stopped_in |=> injector_valve_hold_out)
    else $error("hold dropped early");
  a_gen_pulse: assert property (s0 == `OSS_SRC_GEN_OPEN && $rose(gen_open_req_in) |=> ##1 pins_out[0] [*4] ##1 !pins_out[0])
    else $error("breaker pulse width wrong");
  c_gen_pulse: cover property (s0 == `OSS_SRC_GEN_OPEN && $rose(gen_open_req_in));
  c_pull_end: cover property ($fell(injector_valve_pull_out));
  c_hold_end: cover property ($fell(injector_valve_hold_out));
endmodule
bind oss_selector oss_selector_checker #(.N_OUT(N_OUT)) chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .sel_flat_in(sel_flat_in), .gross_overspeed_in(gross_overspeed_in), .auto_mode_in(auto_mode_in),
  .start_seq_in(start_seq_in), .stop_seq_in(stop_seq_in), .start_cmd_in(start_cmd_in),
  .engine_stopped_in(engine_stopped_in), .gen_open_req_in(gen_open_req_in),
  .injector_valve_pull_out(injector_valve_pull_out), .injector_valve_hold_out(injector_valve_hold_out),
  .pins_out(pins_out));
`default_nettype wire

// ---- verification/oss_selector_bench.sv ----
// oss_selector_bench.sv: directed test of the source selector
// assumes: pulse count 4, pull count 6, every output on one code except in the valve and unmapped steps
`timescale 1ns/1ps
`default_nettype none
`include "oss_map.vh"
module oss_selector_bench;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [55:0] sel = 56'h0;
  logic [23:0] c = 24'h0;
  wire pull;
  wire hold;
  wire [7:0] pins;
  wire [7:0] picks;
  logic [7:0] n0;
  integer fail_count = 0;
  integer num_checks = 0;
  int i;
  int lb[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 11, 15, 16};
  oss_selector #(.N_OUT(8), .PULSE_CYC(32'h4), .PULL_CYC(32'h6)) dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .sel_flat_in(sel), .gross_overspeed_in(c[0]), .start_relay_in(c[1]), .temp_open_in(c[2]),
    .under_freq_in(c[3]), .under_speed_in(c[4]), .maint_due_in(c[5]), .stop_seq_in(c[6]), .auto_mode_in(c[7]),
    .manual_mode_in(c[8]), .preheat_start_in(c[9]), .preheat_expired_in(c[10]), .fuel_xfer_in(c[11]),
    .start_cmd_in(c[12]), .stop_cmd_in(c[13]), .engine_stopped_in(c[14]), .low_idle_in(c[15]),
    .coolant_out_band_in(c[16]), .start_seq_in(c[17]), .gen_open_req_in(c[18]), .gen_close_req_in(c[19]),
    .mains_open_req_in(c[20]), .mains_close_req_in(c[21]), .idle_on_req_in(c[22]), .idle_off_req_in(c[23]),
    .injector_valve_pull_out(pull), .injector_valve_hold_out(hold), .pins_out(pins));
  oss_relay_model rly_u (.clk_in(clk_in), .coil_in(pins[0]), .pick_count_out(picks));
  initial forever #4 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [6:0] lvcode(int b);
    return b < 9 ? `OSS_SRC_GROSS_OVSPD + 7'(b) : (b == 11 ? `OSS_SRC_FUEL_XFER : 7'h2d + 7'(b));
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    chk("reset", pins, 8'h00);
    arst_n_in = 1'b1;
    for (i = 0; i < 12; i++) begin
      sel = {8{lvcode(lb[i])}};
      c[lb[i]] = 1'b1;
      tick(1);
      chk("level on", pins, 8'hff);
      c = 24'h0;
      tick(1);
      chk("level off", pins, 8'h00);
    end
    sel = {8{`OSS_SRC_KEYSWITCH}};
    c[17] = 1'b1;
    tick(1);
    chk("key start", pins, 8'hff);
    c[6] = 1'b1;
    tick(1);
    chk("key stop", pins, 8'h00);
    sel = {8{`OSS_SRC_PREHEAT}};
    c = 24'h200;
    tick(1);
    c = 24'h0;
    tick(3);
    chk("preheat", pins, 8'hff);
    c[10] = 1'b1;
    tick(2);
    chk("preheat end", pins, 8'h00);
    sel = {4{`OSS_SRC_VALVE_HOLD, `OSS_SRC_VALVE_PULL}};
    c = 24'h1000;
    tick(1);
    c = 24'h0;
    tick(2);
    chk("valve on", pins, 8'hff);
    chk("pull out on", {7'h00, pull}, 8'h01);
    tick(6);
    chk("pull end", pins, 8'haa);
    chk("pull out off", {7'h00, pull}, 8'h00);
    c[13] = 1'b1;
    tick(1);
    c[13] = 1'b0;
    tick(3);
    chk("hold run", pins, 8'haa);
    chk("hold out on", {7'h00, hold}, 8'h01);
    c[14] = 1'b1;
    tick(3);
    chk("hold end", pins, 8'h00);
    chk("hold out off", {7'h00, hold}, 8'h00);
    sel = {4{7'h45, 7'h2e}};
    c = 24'hffffff;
    tick(2);
    chk("unmapped", pins, 8'h00);
    c = 24'h0;
    tick(14);
    for (i = 18; i < 24; i++) begin
      sel = {8{7'h2d + 7'(i)}};
      n0 = picks;
      c[i] = 1'b1;
      tick(3);
      chk("pulse", pins, 8'hff);
      tick(9);
      chk("held req", pins, 8'h00);
      c[i] = 1'b0;
      tick(2);
      c[i] = 1'b1;
      tick(12);
      c[i] = 1'b0;
      chk("picks", picks - n0, 8'h02);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
